// ### hdl/lps_ctrl.sv
// Low-power stop and bus clock control, top level
// Rules for this block and for the logic around it
// R1: Broadcast only at execute with everything idle
// R2: Broadcast drives fixed address, write, immediate data
// R3: Broadcast drives type 3, modifier 0, size 2
// R4: Acknowledge or error acknowledge ends broadcast
// R5: Arbitration continues while broadcast is extended
// R6: Broadcast end loads status register from immediate
// R7: Status code 6, halt, then clock disable
// R8: Pipeline contents held unchanged through stop
// R9: Stop entered despite pending; leave on wake
// R10: Unmasked interrupt negates disable, restarts PLL
// R11: Masked interrupt keeps processor stopped
// R12: Source holds level until pending asserted
// R13: Outside logic gives stable clock after disable
// R14: After lock, start interrupt or reset exception
// R15: Alternate master gives up grant before end
// R16: Low-frequency mode sampled at reset or wake
// R17: Clock frequency changes only when allowed
// R18: Normal clock duty cycle within limits
// R19: Clock loss raises flag until reset
// R20: Supervisor only, else privilege trap
// R21: Decode three-word stop instruction
// R22: Low-frequency input ignored outside stop/reset
// R23: Clock-lost flag driven only in normal clocking
module lps_ctrl #(
   parameter int IPL_W = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Instruction stream from the core
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic supervisor,
   input wire logic at_execute,
   input wire logic core_busy,
   input wire logic bus_busy,
   // Bus
   input wire logic transfer_ack,
   input wire logic transfer_error_ack,
   input wire logic bus_grant_in,
   output logic bus_owner_q,
   output logic bcast_active_q,
   output logic [31:0] addr_q,
   output logic read_write_q,
   output logic [31:0] data_out_q,
   output logic [1:0] transfer_type_q,
   output logic [2:0] transfer_modifier_q,
   output logic [1:0] transfer_size_q,
   // Processor state
   output logic [15:0] status_reg_q,
   output logic [3:0] processor_status_lines_q,
   output logic pipeline_hold_q,
   output logic priv_trap_q,
   output logic irq_exception_q,
   // Interrupts
   input wire logic [IPL_W-1:0] interrupt_level_lines,
   output logic interrupt_pending_out_q,
   // Clock control
   input wire logic low_freq_mode_in,
   input wire logic pll_locked,
   output logic clock_disable_indication_q,
   output logic pll_enable_q,
   output logic low_freq_mode_q,
   output logic clock_lost_flag_q,
   output logic clock_lost_flag_oe_q
);
   // Wake compare is only meaningful when the level width matches the mask field
   if (IPL_W != lps_pkg::SR_MASK_MSB - lps_pkg::SR_MASK_LSB + 1) begin : g_bad_ipl_w
      $error("IPL_W must match the status register mask width");
   end

   lps_dec_if dec_bus ();
   lps_pkg::lps_state_t state_q;
   logic ack_q;
   logic out_of_reset_q;
   logic [IPL_W-1:0] sr_mask;
   logic wake;

   assign dec_bus.ack = ack_q;
   assign sr_mask = status_reg_q[lps_pkg::SR_MASK_MSB:lps_pkg::SR_MASK_LSB];
   // Source must hold the level until pending rises [R12]
   assign wake = interrupt_level_lines > sr_mask; // [R10] [R11]

   lps_decode u_dec (
      .clk(clk),
      .arst_n(arst_n),
      .instr_valid(instr_valid),
      .instr_word(instr_word),
      .supervisor(supervisor),
      .dec(dec_bus)
   );

   // Sequencer; pending interrupts do not stop entry once started
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= lps_pkg::ST_RUN;
         ack_q <= 1'h0;
      end else begin
         ack_q <= 1'h0;
         case (state_q)
            lps_pkg::ST_RUN: begin
               if (dec_bus.stop_req && !ack_q) begin
                  state_q <= lps_pkg::ST_QUIET;
                  ack_q <= 1'h1;
               end
            end
            lps_pkg::ST_QUIET: begin
               if (at_execute && !core_busy && !bus_busy) begin
                  state_q <= lps_pkg::ST_BCAST; // [R1] [R9]
               end
            end
            lps_pkg::ST_BCAST: begin
               // Waits as long as outside logic withholds both acks
               if (transfer_ack || transfer_error_ack) begin
                  state_q <= lps_pkg::ST_LOAD; // [R4]
               end
            end
            lps_pkg::ST_LOAD: state_q <= lps_pkg::ST_HALT;
            lps_pkg::ST_HALT: state_q <= lps_pkg::ST_STOPPED; // [R7]
            lps_pkg::ST_STOPPED: begin
               if (wake) begin
                  state_q <= lps_pkg::ST_RELOCK; // [R10] [R9]
               end
            end
            lps_pkg::ST_RELOCK: begin
               // Outside logic must supply a stable clock here [R13]
               if (pll_locked) begin
                  state_q <= lps_pkg::ST_RUN; // [R14]
               end
            end
            default: state_q <= lps_pkg::ST_RUN;
         endcase
      end
   end

   // Broadcast bus drive
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bcast_active_q <= 1'h0;
         addr_q <= 32'h0;
         read_write_q <= 1'h1;
         data_out_q <= 32'h0;
         transfer_type_q <= 2'h0;
         transfer_modifier_q <= 3'h0;
         transfer_size_q <= 2'h0;
      end else begin
         bcast_active_q <= (state_q == lps_pkg::ST_QUIET && at_execute && !core_busy
                            && !bus_busy)
                           || (state_q == lps_pkg::ST_BCAST
                               && !transfer_ack && !transfer_error_ack); // [R4]
         if (state_q == lps_pkg::ST_QUIET) begin
            addr_q <= lps_pkg::BCAST_ADDR; // [R2]
            read_write_q <= lps_pkg::BCAST_RW; // [R2]
            data_out_q <= {16'h0, dec_bus.imm}; // [R2]
            transfer_type_q <= lps_pkg::BCAST_TT; // [R3]
            transfer_modifier_q <= lps_pkg::BCAST_TM; // [R3]
            transfer_size_q <= lps_pkg::BCAST_SIZ; // [R3]
         end
      end
   end

   // Arbitration stays live during the broadcast; no change once stopped
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_owner_q <= 1'h0;
      end else if (state_q != lps_pkg::ST_STOPPED && state_q != lps_pkg::ST_HALT) begin
         bus_owner_q <= bus_grant_in; // [R5] [R15]
      end
   end

   // Status register, status code, pipeline hold, exception pulses
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status_reg_q <= lps_pkg::SR_RESET;
         processor_status_lines_q <= lps_pkg::PST_NORMAL;
         pipeline_hold_q <= 1'h0;
         priv_trap_q <= 1'h0;
         irq_exception_q <= 1'h0;
         interrupt_pending_out_q <= 1'h0;
      end else begin
         priv_trap_q <= dec_bus.priv_trap; // [R20]
         irq_exception_q <= state_q == lps_pkg::ST_RELOCK && pll_locked; // [R14]
         if (state_q == lps_pkg::ST_LOAD) begin
            status_reg_q <= dec_bus.imm; // [R6]
            processor_status_lines_q <= lps_pkg::PST_STOP; // [R7]
         end else if (state_q == lps_pkg::ST_RELOCK && pll_locked) begin
            processor_status_lines_q <= lps_pkg::PST_NORMAL;
         end
         // Queued instructions stay frozen until the exception aborts them
         pipeline_hold_q <= state_q == lps_pkg::ST_LOAD || state_q == lps_pkg::ST_HALT
                            || state_q == lps_pkg::ST_STOPPED
                            || (state_q == lps_pkg::ST_RELOCK && !pll_locked); // [R8]
         if (state_q == lps_pkg::ST_STOPPED && wake) begin
            interrupt_pending_out_q <= 1'h1; // [R12]
         end else if (state_q == lps_pkg::ST_RUN) begin
            interrupt_pending_out_q <= 1'h0;
         end
      end
   end

   // Clock disable and PLL enable
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clock_disable_indication_q <= 1'h0;
         pll_enable_q <= 1'h1;
      end else if (state_q == lps_pkg::ST_HALT) begin
         clock_disable_indication_q <= 1'h1; // [R7]
         pll_enable_q <= 1'h0;
      end else if (state_q == lps_pkg::ST_STOPPED && wake) begin
         clock_disable_indication_q <= 1'h0; // [R10]
         pll_enable_q <= 1'h1; // [R10]
      end
   end

   // Low-frequency mode: caught right after reset release and on every cycle while stopped
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_of_reset_q <= 1'h0;
         low_freq_mode_q <= 1'h0;
      end else begin
         out_of_reset_q <= 1'h1;
         if (!out_of_reset_q || state_q == lps_pkg::ST_STOPPED) begin
            low_freq_mode_q <= low_freq_mode_in; // [R16] [R22]
         end
      end
   end

   // Clock loss in normal clocking; sticky until reset, released otherwise
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clock_lost_flag_q <= 1'h0;
         clock_lost_flag_oe_q <= 1'h0;
      end else begin
         clock_lost_flag_oe_q <= out_of_reset_q && !low_freq_mode_q
                                 && state_q != lps_pkg::ST_STOPPED
                                 && state_q != lps_pkg::ST_RELOCK
                                 && state_q != lps_pkg::ST_HALT; // [R23]
         if (clock_lost_flag_oe_q && !pll_locked) begin
            clock_lost_flag_q <= 1'h1; // [R19]
         end
      end
   end
endmodule : lps_ctrl

// ### hdl/lps_dec_if.sv
// Decoder to controller hand-off for the stop instruction
interface lps_dec_if;
   logic stop_req;
   logic priv_trap;
   logic [15:0] imm;
   logic ack;
   modport dec (output stop_req, output priv_trap, output imm, input ack);
   modport ctl (input stop_req, input priv_trap, input imm, output ack);
endinterface : lps_dec_if

// ### hdl/lps_decode.sv
// Stop instruction decoder: three-word match and privilege check
module lps_decode (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Instruction stream
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic supervisor,
   // Controller side
   lps_dec_if.dec dec
);
   logic [1:0] word_idx_q;
   logic stop_req_q;
   logic trap_q;
   logic [15:0] imm_q;

   assign dec.stop_req = stop_req_q;
   assign dec.priv_trap = trap_q;
   assign dec.imm = imm_q;

   // Opcode match walks through the three words in order
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         word_idx_q <= 2'h0;
      end else if (instr_valid && !stop_req_q) begin
         case (word_idx_q)
            2'h0: word_idx_q <= (instr_word == lps_pkg::OP_WORD0) ? 2'h1 : 2'h0; // [R21]
            2'h1: word_idx_q <= (instr_word == lps_pkg::OP_WORD1) ? 2'h2 : 2'h0; // [R21]
            default: word_idx_q <= 2'h0;
         endcase
      end
   end

   // Third word is the immediate; request holds until the controller takes it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stop_req_q <= 1'h0;
         trap_q <= 1'h0;
         imm_q <= 16'h0;
      end else begin
         trap_q <= 1'h0;
         if (dec.ack) begin
            stop_req_q <= 1'h0;
         end else if (instr_valid && word_idx_q == 2'h2 && !stop_req_q) begin
            imm_q <= instr_word; // [R21]
            if (supervisor) begin
               stop_req_q <= 1'h1; // [R20]
            end else begin
               trap_q <= 1'h1; // [R20]
            end
         end
      end
   end
endmodule : lps_decode

// ### hdl/lps_pkg.sv
// Shared constants and types for the low-power stop clock control
package lps_pkg;
   // Broadcast cycle bus encodings
   localparam logic [31:0] BCAST_ADDR = 32'h0ffffffe;
   localparam logic [1:0] BCAST_TT = 2'h3;
   localparam logic [2:0] BCAST_TM = 3'h0;
   localparam logic [1:0] BCAST_SIZ = 2'h2;
   localparam logic BCAST_RW = 1'h0;
   // Stop instruction opcode words
   localparam logic [15:0] OP_WORD0 = 16'hf800;
   localparam logic [15:0] OP_WORD1 = 16'h01c0;
   // Processor status codes
   localparam logic [3:0] PST_NORMAL = 4'h0;
   localparam logic [3:0] PST_STOP = 4'h6;
   // Status register fields and reset value
   localparam int SR_MASK_LSB = 8;
   localparam int SR_MASK_MSB = 10;
   localparam logic [15:0] SR_RESET = 16'h2700;
   // Controller states
   typedef enum logic [2:0] {
      ST_RUN, ST_QUIET, ST_BCAST, ST_LOAD, ST_HALT, ST_STOPPED, ST_RELOCK
   } lps_state_t;
endpackage : lps_pkg

// ### verif/lps_ctrl_sva.sv
// Concurrent checks on the low-power stop control ports
module lps_ctrl_chk #(
   parameter int IPL_W = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Broadcast cycle
   input wire logic transfer_ack,
   input wire logic transfer_error_ack,
   input wire logic bcast_active_q,
   input wire logic [31:0] addr_q,
   input wire logic read_write_q,
   input wire logic [31:0] data_out_q,
   input wire logic [1:0] transfer_type_q,
   input wire logic [2:0] transfer_modifier_q,
   input wire logic [1:0] transfer_size_q,
   // Stop state and clocking
   input wire logic [15:0] status_reg_q,
   input wire logic [3:0] processor_status_lines_q,
   input wire logic pipeline_hold_q,
   input wire logic [IPL_W-1:0] interrupt_level_lines,
   input wire logic interrupt_pending_out_q,
   input wire logic clock_disable_indication_q,
   input wire logic pll_enable_q,
   input wire logic low_freq_mode_q,
   input wire logic clock_lost_flag_oe_q
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_ack;
      bcast_active_q && (transfer_ack || transfer_error_ack);
   endsequence
   sequence s_halt;
      processor_status_lines_q == 4'h6 && pipeline_hold_q;
   endsequence
   sequence s_up;
      clock_disable_indication_q && interrupt_level_lines > status_reg_q[10:8];
   endsequence
   property p_enc;
      bcast_active_q |-> addr_q == 32'h0ffffffe && read_write_q == 1'b0
         && {transfer_type_q, transfer_modifier_q, transfer_size_q} == 7'h62;
   endproperty
   property p_wait;
      bcast_active_q && !transfer_ack && !transfer_error_ack |=> bcast_active_q;
   endproperty
   property p_stop;
      s_ack |=> !bcast_active_q ##1 s_halt ##1 clock_disable_indication_q && !pll_enable_q;
   endproperty
   property p_load;
      s_ack |-> ##2 status_reg_q == $past(data_out_q[15:0], 2);
   endproperty
   property p_wake;
      s_up |=> !clock_disable_indication_q && pll_enable_q && interrupt_pending_out_q;
   endproperty
   // A masked level must leave the pipeline frozen as well as the clock off
   property p_sleep;
      clock_disable_indication_q && !(interrupt_level_lines > status_reg_q[10:8])
         |=> clock_disable_indication_q && pipeline_hold_q;
   endproperty
   // First edge after reset is the legal sample, so it is excluded
   property p_lfo;
      !clock_disable_indication_q && $past(arst_n) |=> $stable(low_freq_mode_q);
   endproperty
   property p_oe;
      clock_disable_indication_q || low_freq_mode_q |-> !clock_lost_flag_oe_q;
   endproperty
   a_enc: assert property (p_enc) else $error("broadcast encoding wrong");
   a_wait: assert property (p_wait) else $error("broadcast ended unanswered");
   a_stop: assert property (p_stop) else $error("stop entry order wrong");
   a_load: assert property (p_load) else $error("status not loaded");
   a_wake: assert property (p_wake) else $error("no wake on high level");
   a_sleep: assert property (p_sleep) else $error("woke on masked level");
   a_lfo: assert property (p_lfo) else $error("low freq input taken in run");
   a_oe: assert property (p_oe) else $error("lost flag driven out of run");
endmodule : lps_ctrl_chk

bind lps_ctrl lps_ctrl_chk #(.IPL_W(IPL_W)) lps_ctrl_chk_i (
   .clk, .arst_n, .transfer_ack, .transfer_error_ack, .bcast_active_q, .addr_q, .read_write_q,
   .data_out_q, .transfer_type_q, .transfer_modifier_q, .transfer_size_q, .status_reg_q,
   .processor_status_lines_q, .pipeline_hold_q, .interrupt_level_lines, .interrupt_pending_out_q,
   .clock_disable_indication_q, .pll_enable_q, .low_freq_mode_q, .clock_lost_flag_oe_q
);

// ### verif/lps_ctrl_test.sv
// Self-checking testbench for the low-power stop control
module lps_ctrl_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0, supervisor = 1'b1;
   logic at_execute = 1'b1, core_busy = 1'b0, bus_busy = 1'b0, low_freq_mode_in = 1'b0;
   logic use_err = 1'b0, lose_clk = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic [2:0] interrupt_level_lines = 3'h0;
   logic [7:0] ack_wait = 8'h00;
   logic transfer_ack, transfer_error_ack, bus_grant_in, pll_locked, bus_owner_q;
   logic bcast_active_q, read_write_q, pipeline_hold_q, priv_trap_q, irq_exception_q;
   logic interrupt_pending_out_q, clock_disable_indication_q, pll_enable_q;
   logic low_freq_mode_q, clock_lost_flag_q, clock_lost_flag_oe_q;
   logic [31:0] addr_q, data_out_q;
   logic [1:0] transfer_type_q, transfer_size_q;
   logic [2:0] transfer_modifier_q;
   logic [15:0] status_reg_q;
   logic [3:0] processor_status_lines_q;
   int n_mismatch = 0;
   int num_checks = 0;
   // Fixed 50 percent clock, never retimed
   always #2.5 clk = ~clk;
   lps_ctrl lps_ctrl_i (.clk, .arst_n, .instr_valid, .instr_word, .supervisor, .at_execute,
      .core_busy, .bus_busy, .transfer_ack, .transfer_error_ack, .bus_grant_in, .bus_owner_q,
      .bcast_active_q, .addr_q, .read_write_q, .data_out_q, .transfer_type_q,
      .transfer_modifier_q, .transfer_size_q, .status_reg_q, .processor_status_lines_q,
      .pipeline_hold_q, .priv_trap_q, .irq_exception_q, .interrupt_level_lines,
      .interrupt_pending_out_q, .low_freq_mode_in, .pll_locked, .clock_disable_indication_q,
      .pll_enable_q, .low_freq_mode_q, .clock_lost_flag_q, .clock_lost_flag_oe_q);
   lps_sys_model lps_sys_model_i (.clk, .arst_n, .ack_wait, .use_err, .lose_clk,
      .bcast_active_q, .pll_enable_q, .transfer_ack, .transfer_error_ack, .bus_grant_in,
      .pll_locked);
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test
   task automatic wt(ref logic s);
      for (int i = 0; i < 80; i++) begin
         @(posedge clk);
         #1;
         if (s === 1'b1)
            return;
      end
      n_mismatch++;
      finish_test();
   endtask : wt
   task instr(input logic [47:0] ws);
      for (int i = 2; i >= 0; i--) begin
         @(posedge clk);
         instr_valid <= 1'b1;
         instr_word <= ws[i*16+:16];
      end
      @(posedge clk);
      instr_valid <= 1'b0;
   endtask : instr
   task stop_to(input logic [15:0] imm, input logic [7:0] aw, input logic err, input logic busy);
      @(posedge clk);
      ack_wait <= aw;
      use_err <= err;
      core_busy <= busy;
      bus_busy <= busy;
      at_execute <= !busy;
      instr({16'hf800, 16'h01c0, imm});
      if (busy) begin
         repeat (6) @(posedge clk);
         #1;
         chk("early", bcast_active_q, 1'b0);
         @(posedge clk);
         core_busy <= 1'b0;
         repeat (3) @(posedge clk);
         #1;
         chk("early", bcast_active_q, 1'b0);
         @(posedge clk);
         bus_busy <= 1'b0;
         repeat (3) @(posedge clk);
         #1;
         chk("early", bcast_active_q, 1'b0);
         @(posedge clk);
         at_execute <= 1'b1;
      end
      wt(bcast_active_q);
      chk("addr", addr_q, 32'h0ffffffe);
      chk("rw", read_write_q, 1'b0);
      chk("data", data_out_q[15:0], imm);
      chk("attr", {transfer_type_q, transfer_modifier_q, transfer_size_q}, 7'h62);
      // A withheld ack must still let the grant be taken away
      if (aw >= 8'h02) begin
         repeat (2) @(posedge clk);
         #1;
         chk("owner", bus_owner_q, 1'b0);
         chk("extend", bcast_active_q, 1'b1);
      end
      wt(clock_disable_indication_q);
      chk("sr", status_reg_q, imm);
      chk("pst", processor_status_lines_q, 4'h6);
      chk("hold", pipeline_hold_q, 1'b1);
   endtask : stop_to
   task wake(input logic [2:0] l);
      @(posedge clk);
      interrupt_level_lines <= l;
      wt(interrupt_pending_out_q);
      chk("scd", clock_disable_indication_q, 1'b0);
      @(posedge clk);
      interrupt_level_lines <= 3'h0;
      wt(irq_exception_q);
      @(posedge clk);
      #1;
      chk("pst", processor_status_lines_q, 4'h0);
   endtask : wake
   task t_loss;
      @(posedge clk);
      lose_clk <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("lost", clock_lost_flag_q, 1'b1);
      chk("oe", clock_lost_flag_oe_q, 1'b1);
      @(posedge clk);
      arst_n <= 1'b0;
      lose_clk <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("lost", clock_lost_flag_q, 1'b0);
      chk("oe", clock_lost_flag_oe_q, 1'b0);
      @(posedge clk);
      arst_n <= 1'b1;
   endtask : t_loss
   task t_plain;
      stop_to(16'h2300, 8'h00, 1'b0, 1'b1);
      @(posedge clk);
      interrupt_level_lines <= 3'h3;
      repeat (8) @(posedge clk);
      #1;
      chk("scd", clock_disable_indication_q, 1'b1);
      wake(3'h4);
   endtask : t_plain
   task t_pending;
      @(posedge clk);
      interrupt_level_lines <= 3'h6;
      stop_to(16'h2500, 8'h04, 1'b1, 1'b0);
      wake(3'h6);
   endtask : t_pending
   task t_refuse;
      instr({16'hf800, 16'h01c1, 16'h2000});
      @(posedge clk);
      supervisor <= 1'b0;
      instr({16'hf800, 16'h01c0, 16'h2000});
      wt(priv_trap_q);
      chk("bcast", bcast_active_q, 1'b0);
      @(posedge clk);
      supervisor <= 1'b1;
      repeat (12) @(posedge clk);
      #1;
      chk("pst", processor_status_lines_q, 4'h0);
      chk("scd", clock_disable_indication_q, 1'b0);
   endtask : t_refuse
   task t_lfm;
      @(posedge clk);
      low_freq_mode_in <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("lfm", low_freq_mode_q, 1'b0);
      stop_to(16'h2000, 8'h02, 1'b0, 1'b0);
      wake(3'h1);
      chk("lfm", low_freq_mode_q, 1'b1);
      chk("oe", clock_lost_flag_oe_q, 1'b0);
      @(posedge clk);
      low_freq_mode_in <= 1'b0;
      stop_to(16'h2000, 8'h00, 1'b0, 1'b0);
      wake(3'h1);
      chk("lfm", low_freq_mode_q, 1'b0);
   endtask : t_lfm
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      t_loss();
      t_plain();
      t_pending();
      t_refuse();
      t_lfm();
      finish_test();
   end
endmodule : lps_ctrl_test

// ### verif/lps_sys_model.sv
// System logic model: acknowledge, arbiter and PLL lock
module lps_sys_model (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Scenario controls
   input wire logic [7:0] ack_wait,
   input wire logic use_err,
   input wire logic lose_clk,
   // Block side
   input wire logic bcast_active_q,
   input wire logic pll_enable_q,
   output logic transfer_ack,
   output logic transfer_error_ack,
   output logic bus_grant_in,
   output logic pll_locked
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cnt;
   logic [1:0] lk;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 8'h00;
         lk <= 2'h3;
         transfer_ack <= 1'b0;
         transfer_error_ack <= 1'b0;
         bus_grant_in <= 1'b1;
         pll_locked <= 1'b1;
      end else begin
         // Counting stops once answered, so each broadcast gets one pulse
         cnt <= (bcast_active_q && !transfer_ack && !transfer_error_ack) ? cnt + 8'h01 : 8'h00;
         transfer_ack <= bcast_active_q && cnt == ack_wait && !use_err;
         transfer_error_ack <= bcast_active_q && cnt == ack_wait && use_err;
         bus_grant_in <= !bcast_active_q;
         // Lock returns a few cycles after enable, then the clock is stable
         lk <= !pll_enable_q ? 2'h0 : (lk == 2'h3 ? lk : lk + 2'h1);
         pll_locked <= lk == 2'h3 && pll_enable_q && !lose_clk;
      end
   end
endmodule : lps_sys_model
